// [hw/csw_pkg.sv]
package csw_pkg;

  // ************************************************************
  // Register map (byte offsets on the plain register port)
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_RUN_CTRL = 4'h0;   // oscillator_run_control
  localparam logic [ADDR_W-1:0] OFF_CLK_SEL = 4'h1;    // system_clock_select
  localparam logic [ADDR_W-1:0] OFF_STAB_SEL = 4'h2;   // stabilization_time_select
  localparam logic [ADDR_W-1:0] OFF_STAB_STAT = 4'h3;  // stabilization_counter_status

  // ************************************************************
  // Field positions
  // ************************************************************
  // oscillator_run_control
  localparam int BIT_FAST_INTERNAL_OSC_HALT = 0;
  localparam int BIT_MID_INTERNAL_OSC_ENABLE = 1;
  localparam int BIT_SUB_CRYSTAL_HALT = 6;
  localparam int BIT_MAIN_CRYSTAL_HALT = 7;
  // system_clock_select
  localparam int BIT_MID_OSC_SELECT = 0;
  localparam int BIT_MID_OSC_STATUS = 1;
  localparam int BIT_MAIN_CLOCK_SOURCE_SELECT = 4;
  localparam int BIT_MAIN_CLOCK_SOURCE_STATUS = 5;
  localparam int BIT_CPU_CLOCK_SOURCE_SELECT = 6;
  localparam int BIT_CPU_CLOCK_SOURCE_STATUS = 7;
  // stabilization_time_select
  localparam int STAB_SEL_W = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_RUN_CTRL = 8'hc0;  // Crystals halted, fast on-chip running
  localparam logic [7:0] RST_CLK_SEL = 8'h00;   // Main clock, fast on-chip source
  localparam logic [STAB_SEL_W-1:0] RST_STAB_SEL = 3'h7;
  localparam logic [7:0] REG_ZERO = 8'h00;

  // ************************************************************
  // Stabilization counter: flag exponents, bit 7 first
  // ************************************************************
  localparam int STAB_CNT_W = 19;
  localparam int STAB_FLAGS = 8;
  localparam int STAB_EXP [STAB_FLAGS] = '{8, 9, 10, 11, 13, 15, 17, 18};

  // ************************************************************
  // Clock changeover timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SWITCH_SETTLE_NS = 120;
  localparam int SWITCH_SETTLE_CYCLES = (SWITCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 4;

  typedef enum {
    CSW_IDLE,
    CSW_GATE_OFF,
    CSW_SWAP,
    CSW_GATE_ON,
    CSW_REPORT
  } csw_state_type;

endpackage

// [hw/csw_stab_counter.sv]
`timescale 1ns/1ns
module csw_stab_counter
  import csw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [csw_pkg::STAB_SEL_W-1:0] i_sel,
  input wire logic i_xtal_clk,
  output logic [csw_pkg::STAB_FLAGS-1:0] o_flags,
  output logic o_stable
);

  // ************************************************************
  // Crystal clock pin synchroniser and edge detect
  // ************************************************************
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic [STAB_CNT_W-1:0] count_r;

  // Threshold for one flag, flag 0 sitting in register bit 7
  function automatic logic [STAB_CNT_W-1:0] thresh(input int idx);
    thresh = STAB_CNT_W'(1) << STAB_EXP[idx];
  endfunction

  // The second and third stages feed the edge detector
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else
    begin
      sync1_r <= i_xtal_clk;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ************************************************************
  // Elapsed-time counter, cleared while the crystal is halted
  // ************************************************************
  // Saturates at the longest flag so it never wraps and drops flags
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      count_r <= '0;
    else if (!i_run)
      count_r <= '0;
    else if (sync2_r && !sync3_r && count_r < thresh(STAB_FLAGS - 1))
      count_r <= count_r + STAB_CNT_W'(1);
  end

  // Thermometer flags fill from bit 7 down; stable at selected flag
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_flags <= '0;
      o_stable <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < STAB_FLAGS; k++)
        o_flags[STAB_FLAGS-1-k] <= i_run && (count_r >= thresh(k));  // RQ13
      o_stable <= i_run && (count_r >= thresh(int'(i_sel)));  // RQ10
    end
  end

endmodule

// [hw/csw_clock_switch.sv]
// Notes on behaviour
// RQ1: Bit 0 of run control low runs the fast on-chip oscillator.
// RQ2: Software waits 65 us after starting fast oscillator before selecting it.
// RQ3: Bit 1 of run control high runs the middle-speed on-chip oscillator.
// RQ4: Software waits 4 us after enabling middle oscillator before selecting it.
// RQ5: Software leaves sub clock only after the new main oscillator is stable.
// RQ6: Clock select bit 6 low feeds the main clock to CPU and peripherals.
// RQ7: Read-only bit 7 shows active CPU source; software polls before halting sub.
// RQ8: Bit 6 of run control high halts the sub crystal, low runs it.
// RQ9: Software keeps main source select bit 4 fixed while running from sub clock.
// RQ10: Bits 2:0 of stabilization select set crystal wait; 010 gives 2^10 counts.
// RQ11: With an external main clock the wait select need not be written.
// RQ12: Bit 7 of run control low runs main crystal; external clock applied first.
// RQ13: Status register shows elapsed crystal time as thermometer filling from bit 7.
// RQ14: Software skips the stabilization wait for an external main clock.
// RQ15: Middle select bits set make the middle oscillator the main on-chip clock.
// RQ16: Status bits change only once the glitch-free changeover has completed.
`timescale 1ns/1ns
module csw_clock_switch
  import csw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [csw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_main_xtal_clk,
  output logic [7:0] o_rdata,
  output logic o_fast_osc_run,
  output logic o_mid_osc_run,
  output logic o_main_xtal_run,
  output logic o_sub_xtal_run,
  output logic o_cpu_sel_sub,
  output logic o_main_sel_xtal,
  output logic o_mid_sel,
  output logic o_clk_gate_en,
  output logic o_main_stable
);

  // ************************************************************
  // Software-written state
  // ************************************************************
  logic fast_internal_osc_halt_r;
  logic mid_internal_osc_enable_r;
  logic sub_crystal_halt_r;
  logic main_crystal_halt_r;
  logic cpu_clock_source_select_r;
  logic main_clock_source_select_r;
  logic mid_osc_select_r;
  logic [STAB_SEL_W-1:0] stab_select_r;

  // ************************************************************
  // Changeover state and reported status
  // ************************************************************
  csw_state_type state_r;
  csw_state_type state_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic cpu_clock_source_status_r;
  logic main_clock_source_status_r;
  logic mid_osc_status_r;
  logic pending;
  logic settle_done;
  logic [STAB_FLAGS-1:0] stab_flags;
  logic stab_stable;

  // Register write decode used by every register process
  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    wr_hit = i_wr && (i_addr == off);
  endfunction

  // ************************************************************
  // Oscillator run control register
  // ************************************************************
  // Only the four documented bits store; the rest read as zero
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      fast_internal_osc_halt_r <= RST_RUN_CTRL[BIT_FAST_INTERNAL_OSC_HALT];
      mid_internal_osc_enable_r <= RST_RUN_CTRL[BIT_MID_INTERNAL_OSC_ENABLE];
      sub_crystal_halt_r <= RST_RUN_CTRL[BIT_SUB_CRYSTAL_HALT];
      main_crystal_halt_r <= RST_RUN_CTRL[BIT_MAIN_CRYSTAL_HALT];
    end
    else if (wr_hit(OFF_RUN_CTRL))
    begin
      fast_internal_osc_halt_r <= i_wdata[BIT_FAST_INTERNAL_OSC_HALT];  // RQ1
      mid_internal_osc_enable_r <= i_wdata[BIT_MID_INTERNAL_OSC_ENABLE];  // RQ3
      sub_crystal_halt_r <= i_wdata[BIT_SUB_CRYSTAL_HALT];  // RQ8
      main_crystal_halt_r <= i_wdata[BIT_MAIN_CRYSTAL_HALT];  // RQ12
    end
  end

  // ************************************************************
  // System clock select register, writable half
  // ************************************************************
  // Status bits 7, 5 and 1 ignore writes; they follow the changeover
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cpu_clock_source_select_r <= RST_CLK_SEL[BIT_CPU_CLOCK_SOURCE_SELECT];
      main_clock_source_select_r <= RST_CLK_SEL[BIT_MAIN_CLOCK_SOURCE_SELECT];
      mid_osc_select_r <= RST_CLK_SEL[BIT_MID_OSC_SELECT];
    end
    else if (wr_hit(OFF_CLK_SEL))
    begin
      cpu_clock_source_select_r <= i_wdata[BIT_CPU_CLOCK_SOURCE_SELECT];  // RQ6
      main_clock_source_select_r <= i_wdata[BIT_MAIN_CLOCK_SOURCE_SELECT];
      mid_osc_select_r <= i_wdata[BIT_MID_OSC_SELECT];  // RQ15
    end
  end

  // ************************************************************
  // Stabilization time select register
  // ************************************************************
  // Changing it mid-count only moves the stable point, no restart
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      stab_select_r <= RST_STAB_SEL;
    else if (wr_hit(OFF_STAB_SEL))
      stab_select_r <= i_wdata[STAB_SEL_W-1:0];  // RQ10
  end

  // ************************************************************
  // Crystal stabilization counter
  // ************************************************************
  // Counts crystal edges only while the crystal is told to run
  csw_stab_counter csw_stab_counter_i
  (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_run(!main_crystal_halt_r),
    .i_sel(stab_select_r),
    .i_xtal_clk(i_main_xtal_clk),
    .o_flags(stab_flags),
    .o_stable(stab_stable)
  );

  // ************************************************************
  // Oscillator run outputs
  // ************************************************************
  // Registered so the analog enables never see decode glitches
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_fast_osc_run <= !RST_RUN_CTRL[BIT_FAST_INTERNAL_OSC_HALT];
      o_mid_osc_run <= RST_RUN_CTRL[BIT_MID_INTERNAL_OSC_ENABLE];
      o_sub_xtal_run <= !RST_RUN_CTRL[BIT_SUB_CRYSTAL_HALT];
      o_main_xtal_run <= !RST_RUN_CTRL[BIT_MAIN_CRYSTAL_HALT];
      o_main_stable <= 1'b0;
    end
    else
    begin
      o_fast_osc_run <= !fast_internal_osc_halt_r;  // RQ1
      o_mid_osc_run <= mid_internal_osc_enable_r;  // RQ3
      o_sub_xtal_run <= !sub_crystal_halt_r;  // RQ8
      o_main_xtal_run <= !main_crystal_halt_r;  // RQ12
      o_main_stable <= stab_stable;
    end
  end

  // ************************************************************
  // Glitch-free changeover sequencer
  // ************************************************************
  // Any difference between request and applied select starts a swap
  assign pending = (cpu_clock_source_select_r != o_cpu_sel_sub)
    || (main_clock_source_select_r != o_main_sel_xtal)
    || (mid_osc_select_r != o_mid_sel);
  assign settle_done = (settle_r == SETTLE_W'(SWITCH_SETTLE_CYCLES - 1));

  // Gate off, swap, gate on, then report; status never runs ahead
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CSW_IDLE:
      begin
        if (pending)
          state_nxt = CSW_GATE_OFF;
      end
      CSW_GATE_OFF:
      begin
        if (settle_done)
          state_nxt = CSW_SWAP;
      end
      CSW_SWAP:
        state_nxt = CSW_GATE_ON;
      CSW_GATE_ON:
      begin
        if (settle_done)
          state_nxt = CSW_REPORT;
      end
      CSW_REPORT:
        state_nxt = CSW_IDLE;
      default:
        state_nxt = CSW_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      state_r <= CSW_IDLE;
    else
      state_r <= state_nxt;
  end

  // Settle counter runs in both gated-wait states
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      settle_r <= '0;
    else if ((state_r == CSW_GATE_OFF || state_r == CSW_GATE_ON) && !settle_done)
      settle_r <= settle_r + SETTLE_W'(1);
    else
      settle_r <= '0;
  end

  // Clock gate drops before the selects move and returns after
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_clk_gate_en <= 1'b1;
    else if (state_nxt == CSW_GATE_OFF)
      o_clk_gate_en <= 1'b0;
    else if (state_r == CSW_GATE_ON && settle_done)
      o_clk_gate_en <= 1'b1;
  end

  // Selects change only while the gate is closed
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_cpu_sel_sub <= RST_CLK_SEL[BIT_CPU_CLOCK_SOURCE_SELECT];
      o_main_sel_xtal <= RST_CLK_SEL[BIT_MAIN_CLOCK_SOURCE_SELECT];
      o_mid_sel <= RST_CLK_SEL[BIT_MID_OSC_SELECT];
    end
    else if (state_r == CSW_SWAP)
    begin
      o_cpu_sel_sub <= cpu_clock_source_select_r;  // RQ6
      o_main_sel_xtal <= main_clock_source_select_r;
      o_mid_sel <= mid_osc_select_r;  // RQ15
    end
  end

  // Status follows the applied selects only after the gate reopens
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cpu_clock_source_status_r <= RST_CLK_SEL[BIT_CPU_CLOCK_SOURCE_STATUS];
      main_clock_source_status_r <= RST_CLK_SEL[BIT_MAIN_CLOCK_SOURCE_STATUS];
      mid_osc_status_r <= RST_CLK_SEL[BIT_MID_OSC_STATUS];
    end
    else if (state_r == CSW_REPORT)
    begin
      cpu_clock_source_status_r <= o_cpu_sel_sub;  // RQ16
      main_clock_source_status_r <= o_main_sel_xtal;  // RQ16
      mid_osc_status_r <= o_mid_sel;  // RQ16
    end
  end

  // ************************************************************
  // Read port, data one cycle after the strobe
  // ************************************************************
  // Unmapped offsets and idle cycles read zero
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= REG_ZERO;
    else if (!i_rd)
      o_rdata <= REG_ZERO;
    else
    begin
      o_rdata <= REG_ZERO;
      case (i_addr)
        OFF_RUN_CTRL:
        begin
          o_rdata[BIT_FAST_INTERNAL_OSC_HALT] <= fast_internal_osc_halt_r;
          o_rdata[BIT_MID_INTERNAL_OSC_ENABLE] <= mid_internal_osc_enable_r;
          o_rdata[BIT_SUB_CRYSTAL_HALT] <= sub_crystal_halt_r;
          o_rdata[BIT_MAIN_CRYSTAL_HALT] <= main_crystal_halt_r;
        end
        OFF_CLK_SEL:
        begin
          o_rdata[BIT_CPU_CLOCK_SOURCE_STATUS] <= cpu_clock_source_status_r;  // RQ7
          o_rdata[BIT_CPU_CLOCK_SOURCE_SELECT] <= cpu_clock_source_select_r;
          o_rdata[BIT_MAIN_CLOCK_SOURCE_STATUS] <= main_clock_source_status_r;
          o_rdata[BIT_MAIN_CLOCK_SOURCE_SELECT] <= main_clock_source_select_r;
          o_rdata[BIT_MID_OSC_STATUS] <= mid_osc_status_r;
          o_rdata[BIT_MID_OSC_SELECT] <= mid_osc_select_r;
        end
        OFF_STAB_SEL:
          o_rdata[STAB_SEL_W-1:0] <= stab_select_r;
        OFF_STAB_STAT:
          o_rdata <= stab_flags;  // RQ13
        default:
          o_rdata <= REG_ZERO;
      endcase
    end
  end

endmodule

// [verification/csw_clock_switch_assertions.sv]
`timescale 1ns/1ns
module csw_clock_switch_assertions
  import csw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [csw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_main_xtal_clk,
  input wire logic [7:0] o_rdata,
  input wire logic o_fast_osc_run,
  input wire logic o_mid_osc_run,
  input wire logic o_main_xtal_run,
  input wire logic o_sub_xtal_run,
  input wire logic o_cpu_sel_sub,
  input wire logic o_main_sel_xtal,
  input wire logic o_mid_sel,
  input wire logic o_clk_gate_en,
  input wire logic o_main_stable
);
  // ****************
  // Decoded writes
  // ****************
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  logic run_wr;
  logic sel_wr;
  // Decoded once so each property stays short
  assign run_wr = i_wr && (i_addr == OFF_RUN_CTRL);
  assign sel_wr = i_wr && (i_addr == OFF_CLK_SEL);
  // ****************
  // Properties
  // ****************
  // Run outputs are a second register stage behind the stored bits
  property p_fast_run;
    run_wr |-> ##2 o_fast_osc_run == !$past(i_wdata[0], 2);
  endproperty
  a_fast_run: assert property (p_fast_run) else $error("fast osc run wrong");
  property p_mid_run;
    run_wr |-> ##2 o_mid_osc_run == $past(i_wdata[1], 2);
  endproperty
  a_mid_run: assert property (p_mid_run) else $error("mid osc run wrong");
  property p_sub_run;
    run_wr |-> ##2 o_sub_xtal_run == !$past(i_wdata[6], 2);
  endproperty
  a_sub_run: assert property (p_sub_run) else $error("sub crystal run wrong");
  property p_main_run;
    run_wr |-> ##2 o_main_xtal_run == !$past(i_wdata[7], 2);
  endproperty
  a_main_run: assert property (p_main_run) else $error("main crystal run wrong");
  property p_gate_fall;
    sel_wr && o_clk_gate_en && (i_wdata[6] != o_cpu_sel_sub) |-> ##[1:4] !o_clk_gate_en;
  endproperty
  a_gate_fall: assert property (p_gate_fall) else $error("no changeover started");
  // Selects may only move while the gate has been shut for a cycle
  property p_swap_gated;
    $changed({o_cpu_sel_sub, o_main_sel_xtal, o_mid_sel}) |-> !o_clk_gate_en && !$past(o_clk_gate_en);
  endproperty
  a_swap_gated: assert property (p_swap_gated) else $error("select moved with gate open");
  property p_gate_span;
    $fell(o_clk_gate_en) |-> !o_clk_gate_en [*5] ##[1:8] o_clk_gate_en;
  endproperty
  a_gate_span: assert property (p_gate_span) else $error("gate low span wrong");
  property p_status_match;
    i_rd && i_addr == OFF_CLK_SEL && o_clk_gate_en && $past(o_clk_gate_en) && $past(o_clk_gate_en, 2)
      |=> {o_rdata[7], o_rdata[5], o_rdata[1]} == $past({o_cpu_sel_sub, o_main_sel_xtal, o_mid_sel});
  endproperty
  a_status_match: assert property (p_status_match) else $error("status differs from applied");
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_unmapped;
    i_rd && (i_addr > OFF_STAB_STAT) |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind csw_clock_switch csw_clock_switch_assertions csw_clock_switch_assertions_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_main_xtal_clk(i_main_xtal_clk), .o_rdata(o_rdata), .o_fast_osc_run(o_fast_osc_run),
  .o_mid_osc_run(o_mid_osc_run), .o_main_xtal_run(o_main_xtal_run), .o_sub_xtal_run(o_sub_xtal_run),
  .o_cpu_sel_sub(o_cpu_sel_sub), .o_main_sel_xtal(o_main_sel_xtal), .o_mid_sel(o_mid_sel),
  .o_clk_gate_en(o_clk_gate_en), .o_main_stable(o_main_stable));

// [verification/csw_clock_switch_tb_top.sv]
`timescale 1ns/1ns
module csw_clock_switch_tb_top;
  import csw_pkg::*;
  // ****************
  // Signals
  // ****************
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_main_xtal_clk = 1'b0;
  logic xtal_on = 1'b0;
  logic xtal_ph = 1'b0;
  logic [7:0] o_rdata;
  logic [7:0] rv;
  logic o_fast_osc_run, o_mid_osc_run, o_main_xtal_run, o_sub_xtal_run;
  logic o_cpu_sel_sub, o_main_sel_xtal, o_mid_sel, o_clk_gate_en, o_main_stable;
  int num_errors = 0;
  int num_checks = 0;
  csw_clock_switch csw_clock_switch_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_main_xtal_clk(i_main_xtal_clk), .o_rdata(o_rdata), .o_fast_osc_run(o_fast_osc_run),
    .o_mid_osc_run(o_mid_osc_run), .o_main_xtal_run(o_main_xtal_run), .o_sub_xtal_run(o_sub_xtal_run),
    .o_cpu_sel_sub(o_cpu_sel_sub), .o_main_sel_xtal(o_main_sel_xtal), .o_mid_sel(o_mid_sel),
    .o_clk_gate_en(o_clk_gate_en), .o_main_stable(o_main_stable));
  // ****************
  // Clocks
  // ****************
  // Bus clock, 40 ns
  always #20 i_clock = ~i_clock;
  // Crystal pin at 6.25 MHz, safely under the synchroniser limit
  always @(posedge i_clock)
  begin
    xtal_ph <= ~xtal_ph;
    if (xtal_on && xtal_ph)
      i_main_xtal_clk <= ~i_main_xtal_clk;
  end
  // ****************
  // Bus and compare tasks
  // ****************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic ob(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // Trailing edge lets the registered run outputs follow the write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    rd(a);
    chk(rv, exp);
  endtask
  // Bounded poll of one clock select status bit
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    rd(OFF_CLK_SEL);
    while (rv[b] !== v && n < 40)
    begin
      rd(OFF_CLK_SEL);
      n++;
    end
    ob(rv[b], v);
  endtask
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rchk(OFF_RUN_CTRL, 8'hc0);
    rchk(OFF_CLK_SEL, 8'h00);
    rchk(OFF_STAB_SEL, 8'h07);
    wr(4'h5, 8'hff);
    wr(OFF_STAB_STAT, 8'hff);
    rchk(4'hf, 8'h00);
    rchk(OFF_STAB_STAT, 8'h00);
    ob(o_fast_osc_run, 1'b1);
  endtask
  task automatic t_run;
    wr(OFF_RUN_CTRL, 8'hff);
    rchk(OFF_RUN_CTRL, 8'hc3);
    ob(o_fast_osc_run, 1'b0);
    ob(o_mid_osc_run, 1'b1);
    ob(o_main_xtal_run, 1'b0);
    ob(o_sub_xtal_run, 1'b0);
    wr(OFF_RUN_CTRL, 8'h82);
    ob(o_fast_osc_run, 1'b1);
    ob(o_sub_xtal_run, 1'b1);
  endtask
  // Sub clock then middle oscillator, status lagging the select
  task automatic t_mid;
    wr(OFF_CLK_SEL, 8'h40);
    ob(o_clk_gate_en, 1'b0);
    rchk(OFF_CLK_SEL, 8'h40);
    poll(7, 1'b1);
    ob(o_cpu_sel_sub, 1'b1);
    ob(o_clk_gate_en, 1'b1);
    wr(OFF_CLK_SEL, 8'h01);
    poll(7, 1'b0);
    rchk(OFF_CLK_SEL, 8'h03);
    ob(o_mid_sel, 1'b1);
    wr(OFF_RUN_CTRL, 8'hc2);
    ob(o_sub_xtal_run, 1'b0);
  endtask
  // Back to fast oscillator; status bits written as 1 must stay put
  task automatic t_fast;
    wr(OFF_RUN_CTRL, 8'h82);
    wr(OFF_CLK_SEL, 8'h41);
    poll(7, 1'b1);
    // Fast oscillator settle, 65 us, before it may be chosen
    repeat (1625) @(posedge i_clock);
    wr(OFF_CLK_SEL, 8'ha2);
    poll(7, 1'b0);
    rchk(OFF_CLK_SEL, 8'h00);
    ob(o_mid_sel, 1'b0);
  endtask
  task automatic t_xtal;
    int n;
    wr(OFF_STAB_SEL, 8'hfa);
    rchk(OFF_STAB_SEL, 8'h02);
    wr(OFF_RUN_CTRL, 8'h02);
    ob(o_main_xtal_run, 1'b1);
    xtal_on = 1'b1;
    n = 0;
    rd(OFF_STAB_STAT);
    while (rv[5] !== 1'b1 && n < 3000)
    begin
      chk(rv & ~{1'b1, rv[7:1]}, 8'h00);
      rd(OFF_STAB_STAT);
      n++;
    end
    chk(rv, 8'he0);
    ob(o_main_stable, 1'b1);
    wr(OFF_CLK_SEL, 8'h10);
    poll(5, 1'b1);
    wr(OFF_CLK_SEL, 8'h50);
    poll(7, 1'b1);
    wr(OFF_CLK_SEL, 8'h10);
    poll(7, 1'b0);
    rchk(OFF_CLK_SEL, 8'h30);
    ob(o_main_sel_xtal, 1'b1);
    wr(OFF_CLK_SEL, 8'h00);
    poll(5, 1'b0);
    wr(OFF_RUN_CTRL, 8'hc2);
    xtal_on = 1'b0;
    repeat (4) @(posedge i_clock);
    rchk(OFF_STAB_STAT, 8'h00);
    ob(o_main_stable, 1'b0);
  endtask
  // External main clock: applied before the halt bit clears, no wait
  task automatic t_ext;
    xtal_on = 1'b1;
    wr(OFF_RUN_CTRL, 8'h42);
    ob(o_main_xtal_run, 1'b1);
    wr(OFF_CLK_SEL, 8'h10);
    poll(5, 1'b1);
    ob(o_main_stable, 1'b0);
    wr(OFF_CLK_SEL, 8'h00);
    poll(5, 1'b0);
    wr(OFF_RUN_CTRL, 8'hc2);
    xtal_on = 1'b0;
    ob(o_main_xtal_run, 1'b0);
  endtask
  // ****************
  // Sequence and watchdog
  // ****************
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_run();
    // Middle oscillator settle before it may be chosen
    repeat (100) @(posedge i_clock);
    t_mid();
    t_fast();
    t_xtal();
    t_ext();
    end_of_test();
  end
  // Whole run needs about 6k cycles; five times that means a hang
  initial
  begin
    #(40 * 30000);
    num_errors++;
    end_of_test();
  end
endmodule
